// ### hdl/dtcc_pkg.sv
package dtcc_pkg;

  // Transfer window is F0000H..FFFFFH; only the low 16 bits travel in descriptors
  localparam logic [3:0] WINDOW_PAGE = 4'hf;
  localparam logic [15:0] WINDOW_LO = 16'h0000;
  localparam logic [15:0] WINDOW_HI = 16'hffff;
  localparam int WINDOW_KBYTES = 64;

  // Region bounds inside the window (offsets from F0000H)
  localparam logic [15:0] EXT_SPECIAL_LO = 16'h0000;
  localparam logic [15:0] EXT_SPECIAL_HI = 16'h07ff;
  localparam logic [15:0] MIRROR_LO = 16'h2000;
  localparam logic [15:0] MIRROR_HI = 16'hbfff;
  localparam logic [15:0] RAM_LO = 16'hc000;
  localparam logic [15:0] RAM_HI = 16'hfedf;
  localparam logic [15:0] GPR_LO = 16'hfee0;
  localparam logic [15:0] GPR_HI = 16'hfeff;
  localparam logic [15:0] SPECIAL_LO = 16'hff00;
  localparam logic [15:0] SPECIAL_HI = 16'hffff;

  // Count of 8'h00 stands for 256 transfers in normal mode
  localparam logic [7:0] COUNT_LAST = 8'h01;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  typedef struct packed {
    logic enable;
    logic repeat_mode;
    logic unit16;
    logic src_inc;
    logic dst_inc;
    logic repeat_on_dst;
    logic [7:0] channel_transfer_count;
    logic [7:0] channel_reload_count;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] repeat_base;
  } dtcc_desc_type;

  typedef struct packed {
    logic we;
    logic unit16;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dtcc_mem_type;

  typedef enum logic {
    DTCC_SIDE_SRC,
    DTCC_SIDE_DST
  } dtcc_side_type;

endpackage : dtcc_pkg

// ### hdl/dtcc_region_check.sv
`timescale 1ns/1ps
module dtcc_region_check
  import dtcc_pkg::*;
(
  input wire logic [15:0] addr,
  input wire dtcc_pkg::dtcc_side_type side,
  output logic ok
);
  logic in_special;
  logic in_ext;
  logic in_ram;
  logic in_mirror;

  assign in_special = (addr >= SPECIAL_LO) && (addr <= SPECIAL_HI);
  assign in_ext = (addr >= EXT_SPECIAL_LO) && (addr <= EXT_SPECIAL_HI);
  assign in_ram = (addr >= RAM_LO) && (addr <= RAM_HI);
  assign in_mirror = (addr >= MIRROR_LO) && (addr <= MIRROR_HI);

  // General-purpose registers fall in no accepted region
  always_comb begin
    if (side == DTCC_SIDE_SRC) begin
      ok = in_special | in_ext | in_ram | in_mirror;
    end else begin
      ok = in_special | in_ext | in_ram;
    end
  end
endmodule : dtcc_region_check

// ### hdl/dtcc_core.sv
`timescale 1ns/1ps
module dtcc_core (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic act_valid,
  output logic act_ready,
  input dtcc_pkg::dtcc_desc_type act_desc,
  output logic mem_req,
  output dtcc_pkg::dtcc_mem_type mem_out,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic done,
  output logic err,
  output logic src_irq,
  output dtcc_pkg::dtcc_desc_type desc_out
);
  import dtcc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_DONE
  } dtcc_state_type;

  dtcc_state_type state_reg;
  dtcc_desc_type cap_reg;
  dtcc_desc_type desc_next;
  dtcc_desc_type desc_out_reg;
  logic [15:0] data_reg;
  logic done_reg;
  logic err_reg;
  logic irq_reg;
  logic src_ok;
  logic dst_ok;
  logic accept;
  logic legal;
  logic [15:0] step;

  dtcc_region_check u_src_check (
    .addr(act_desc.src),
    .side(DTCC_SIDE_SRC),
    .ok(src_ok)
  );

  dtcc_region_check u_dst_check (
    .addr(act_desc.dst),
    .side(DTCC_SIDE_DST),
    .ok(dst_ok)
  );

  assign act_ready = ce && (state_reg == ST_IDLE);
  assign accept = act_valid && act_ready;
  // Disabled channels and illegal areas are answered without a bus cycle
  assign legal = act_desc.enable && src_ok && dst_ok;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg <= legal ? ST_READ : ST_DONE;
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            state_reg <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cap_reg <= '0;
      err_reg <= 1'b0;
    end else if (ce && accept) begin
      cap_reg <= act_desc;
      err_reg <= !legal;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_reg <= 16'h0000;
    end else if (ce && state_reg == ST_READ && mem_ack) begin
      // Upper byte dropped for byte units
      data_reg <= cap_reg.unit16 ? mem_rdata : {8'h00, mem_rdata[7:0]};
    end
  end

  // Bus address always carries the fixed upper page
  assign mem_req = (state_reg == ST_READ) || (state_reg == ST_WRITE);
  always_comb begin
    mem_out.we = (state_reg == ST_WRITE);
    mem_out.unit16 = cap_reg.unit16;
    mem_out.addr = {WINDOW_PAGE, (state_reg == ST_WRITE) ? cap_reg.dst : cap_reg.src};
    mem_out.wdata = data_reg;
  end

  assign step = cap_reg.unit16 ? STEP_WORD : STEP_BYTE;

  always_comb begin
    desc_next = cap_reg;
    // 16-bit address arithmetic wraps inside the window
    if (cap_reg.src_inc) begin
      desc_next.src = cap_reg.src + step;
    end
    if (cap_reg.dst_inc) begin
      desc_next.dst = cap_reg.dst + step;
    end
    desc_next.channel_transfer_count = cap_reg.channel_transfer_count - COUNT_LAST;
    if (cap_reg.channel_transfer_count == COUNT_LAST) begin
      if (cap_reg.repeat_mode) begin
        desc_next.channel_transfer_count = cap_reg.channel_reload_count;
        if (cap_reg.repeat_on_dst) begin
          desc_next.dst = cap_reg.repeat_base;
        end else begin
          desc_next.src = cap_reg.repeat_base;
        end
      end else begin
        desc_next.enable = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      desc_out_reg <= '0;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
      if (state_reg == ST_DONE) begin
        done_reg <= 1'b1;
        desc_out_reg <= err_reg ? cap_reg : desc_next;
        irq_reg <= !err_reg && !cap_reg.repeat_mode
          && (cap_reg.channel_transfer_count == COUNT_LAST);
      end
    end
  end

  assign done = done_reg;
  assign err = done_reg && err_reg;
  assign src_irq = irq_reg;
  assign desc_out = desc_out_reg;

  default clocking dtcc_cb @(posedge clock iff ce);
  endclocking
  default disable iff (!rstn);

  logic src_ok_cap;
  logic dst_ok_cap;
  dtcc_region_check u_src_chk_cap (
    .addr(cap_reg.src),
    .side(DTCC_SIDE_SRC),
    .ok(src_ok_cap)
  );
  dtcc_region_check u_dst_chk_cap (
    .addr(cap_reg.dst),
    .side(DTCC_SIDE_DST),
    .ok(dst_ok_cap)
  );

  a_window_page: assert property (mem_req |-> mem_out.addr[19:16] == WINDOW_PAGE)
    else $error("access outside window");
  a_source_legal: assert property (mem_req && !mem_out.we |-> src_ok_cap)
    else $error("illegal source area");
  a_dest_legal: assert property (mem_req && mem_out.we |-> dst_ok_cap)
    else $error("illegal destination area");
  a_count_step: assert property (done && !err && cap_reg.channel_transfer_count != COUNT_LAST
    |-> desc_out.channel_transfer_count == $past(cap_reg.channel_transfer_count) - COUNT_LAST)
    else $error("count not decremented");
  a_unit_width: assert property (mem_req && mem_out.we && !cap_reg.unit16 |-> mem_out.wdata[15:8] == 8'h00)
    else $error("byte unit carries upper byte");
  a_normal_stop: assert property (done && !err && !cap_reg.repeat_mode
    && cap_reg.channel_transfer_count == COUNT_LAST |-> !desc_out.enable)
    else $error("normal channel not stopped");
  a_repeat_reload: assert property (done && !err && cap_reg.repeat_mode
    && cap_reg.channel_transfer_count == COUNT_LAST
    |-> desc_out.channel_transfer_count == cap_reg.channel_reload_count && desc_out.enable)
    else $error("repeat reload missing");
  a_fixed_source: assert property (done && !err && !cap_reg.src_inc
    && !(cap_reg.repeat_mode && !cap_reg.repeat_on_dst && cap_reg.channel_transfer_count == COUNT_LAST)
    |-> desc_out.src == cap_reg.src)
    else $error("fixed source moved");
  a_inc_dest: assert property (done && !err && cap_reg.dst_inc && !cap_reg.repeat_mode
    |-> desc_out.dst == cap_reg.dst + step)
    else $error("destination not incremented");
  a_irq_cause: assert property (src_irq |-> done && !err && !cap_reg.repeat_mode
    && cap_reg.channel_transfer_count == COUNT_LAST)
    else $error("interrupt without final transfer");
  a_irq_raised: assert property (state_reg == ST_DONE && !err_reg && !cap_reg.repeat_mode
    && cap_reg.channel_transfer_count == COUNT_LAST |=> src_irq)
    else $error("final transfer without interrupt");

  c_normal_end: cover property (src_irq);
  c_repeat_wrap: cover property (done && !err && cap_reg.repeat_mode && cap_reg.channel_transfer_count == COUNT_LAST);
  c_word_move: cover property (mem_req && mem_out.we && cap_reg.unit16 && mem_ack);
  c_refused: cover property (err);
endmodule : dtcc_core

// ### sim/dtcc_mem_model.sv
`timescale 1ns/1ps
module dtcc_mem_model
  import dtcc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic mem_req,
  input dtcc_pkg::dtcc_mem_type mem_out,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  input wire logic [1:0] delay,
  output dtcc_pkg::dtcc_mem_type wr_last,
  output int acc_count
);
  logic [1:0] wait_reg;
  logic [15:0] noise_reg;
  // Zero delay acks in the first request cycle
  // No ack while the core is frozen, else a transfer would be lost
  assign mem_ack = mem_req && ce && (wait_reg == delay);
  // Undriven data line shows a moving pattern, not the last read
  assign mem_rdata = (mem_ack && !mem_out.we) ? ~mem_out.addr[15:0] : noise_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 2'h0;
      noise_reg <= 16'h0000;
      wr_last <= '0;
      acc_count <= 0;
    end else if (ce) begin
      noise_reg <= noise_reg + 16'h3b1d;
      wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
      if (mem_ack) acc_count <= acc_count + 1;
      if (mem_ack && mem_out.we) wr_last <= mem_out;
    end
  end
endmodule : dtcc_mem_model

// ### sim/data_transfer_controller_core_tb.sv
`timescale 1ns/1ps
module data_transfer_controller_core_tb;
  import dtcc_pkg::*;
  logic clock, rstn, ce, act_valid, act_ready, mem_req, mem_ack, done, err, src_irq;
  logic [15:0] mem_rdata, lfsr;
  logic [1:0] delay;
  logic [79:0] r;
  dtcc_desc_type act_desc, desc_out, d;
  dtcc_mem_type mem_out, wr_last;
  int acc_count, miscompares, tests_run;
  dtcc_core dtcc_core_inst(.clock(clock), .rstn(rstn), .ce(ce), .act_valid(act_valid),
    .act_ready(act_ready), .act_desc(act_desc), .mem_req(mem_req), .mem_out(mem_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done), .err(err), .src_irq(src_irq),
    .desc_out(desc_out));
  dtcc_mem_model dtcc_mem_model_inst(.clock(clock), .rstn(rstn), .ce(ce), .mem_req(mem_req),
    .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .delay(delay),
    .wr_last(wr_last), .acc_count(acc_count));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [15:0] next_rand(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand
  function automatic bit in_area(logic [15:0] a, bit to_dst);
    return a <= EXT_SPECIAL_HI || (!to_dst && a >= MIRROR_LO && a <= MIRROR_HI) ||
      (a >= RAM_LO && a <= RAM_HI) || a >= SPECIAL_LO;
  endfunction : in_area
  task automatic stop_test;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic check(logic [79:0] got, logic [79:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic run(dtcc_desc_type x);
    dtcc_desc_type e;
    logic [15:0] step, rd;
    bit bad, last;
    int n, acc0;
    e = x;
    bad = !x.enable || !in_area(x.src, 0) || !in_area(x.dst, 1);
    step = x.unit16 ? 16'h0002 : 16'h0001;
    last = x.channel_transfer_count == 8'h01;
    rd = x.unit16 ? ~x.src : {8'h00, ~x.src[7:0]};
    if (!bad) begin
      // Count 0 stands for 256 and wraps to 255
      e.channel_transfer_count = x.channel_transfer_count - 8'h01;
      if (x.src_inc) e.src = x.src + step;
      if (x.dst_inc) e.dst = x.dst + step;
      if (last && x.repeat_mode) begin
        e.channel_transfer_count = x.channel_reload_count;
        if (x.repeat_on_dst) e.dst = x.repeat_base;
        else e.src = x.repeat_base;
      end
      if (last && !x.repeat_mode) e.enable = 1'b0;
    end
    acc0 = acc_count;
    act_desc = x;
    act_valid = 1'b1;
    n = 0;
    while (!act_ready && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    @(posedge clock);
    #1 act_valid = 1'b0;
    if (x.channel_reload_count[0]) begin
      // Frozen core must hold its phase and raise nothing
      ce = 1'b0;
      repeat (3) @(posedge clock);
      #1 check({mem_req, done, act_ready}, {!bad, 2'b00});
      ce = 1'b1;
    end
    while (!done && n < 60) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 60) begin
      miscompares++;
      stop_test();
    end
    check(err, bad);
    check(src_irq, !bad && last && !x.repeat_mode);
    check(desc_out, bad ? x : e);
    check(acc_count - acc0, bad ? 0 : 2);
    if (!bad) check(wr_last, {1'b1, x.unit16, 4'hf, x.dst, rd});
  endtask : run
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    act_valid = 1'b0;
    act_desc = '0;
    delay = 2'h0;
    lfsr = 16'h0007;
    r = '0;
    miscompares = 0;
    tests_run = 0;
    repeat (20) @(posedge clock);
    #1 rstn = 1'b1;
    run({6'b100110, 8'h01, 8'h00, 16'hc010, 16'hff20, 16'h0000});
    run({6'b101100, 8'h00, 8'h00, 16'h2000, 16'hc100, 16'h0000});
    run({6'b111011, 8'h01, 8'h05, 16'hff00, 16'hc200, 16'hc180});
    run({6'b110100, 8'h01, 8'h03, 16'hc300, 16'h0400, 16'hc2f0});
    run({6'b100110, 8'h02, 8'h00, 16'hc000, 16'h2100, 16'h0000});
    run({6'b100110, 8'h02, 8'h00, 16'hfee4, 16'hc000, 16'h0000});
    run({6'b000110, 8'h02, 8'h00, 16'hc000, 16'hc002, 16'h0000});
    // Reset in the middle of a slow read: the bus and all pulses must drop at once
    act_desc = {6'b100110, 8'h01, 8'h00, 16'hc010, 16'hc400, 16'h0000};
    delay = 2'h3;
    act_valid = 1'b1;
    @(posedge clock);
    #1 act_valid = 1'b0;
    check(mem_req, 1'b1);
    rstn = 1'b0;
    #1 check({mem_req, done, err, src_irq}, 4'h0);
    @(posedge clock);
    #1 rstn = 1'b1;
    // Random descriptors, mostly enabled, with slow and prompt memory
    repeat (80) begin
      repeat (5) begin
        lfsr = next_rand(lfsr);
        r = {r[63:0], lfsr};
      end
      d = r[69:0];
      d.enable = lfsr[2] | lfsr[3];
      if (lfsr[0]) d.dst[15:14] = 2'b11;
      if (lfsr[4]) d.channel_transfer_count[7:1] = 7'h00;
      delay = lfsr[6:5];
      run(d);
    end
    stop_test();
  end
endmodule : data_transfer_controller_core_tb
